/* File: core/strap_cfg_pkg.sv */
package strap_cfg_pkg;

  // Boot select decode, {boot_source_bit, boot_mode_bit}
  localparam logic [1:0] BOOT_INT_FLASH = 2'h0;
  localparam logic [1:0] BOOT_SERIAL = 2'h1;
  localparam logic [1:0] BOOT_EXT_MEM = 2'h2;
  localparam logic [1:0] BOOT_RESERVED = 2'h3;

  // Reset sources
  localparam logic [2:0] RST_SRC_POWER_ON = 3'h0;
  localparam logic [2:0] RST_SRC_EXTERNAL = 3'h1;
  localparam logic [2:0] RST_SRC_WATCHDOG = 3'h2;
  localparam logic [2:0] RST_SRC_DEBUG_PORT = 3'h3;
  localparam logic [2:0] RST_SRC_SW_EXTERNAL = 3'h4;
  localparam logic [2:0] RST_SRC_SW_SYSTEM = 3'h5;

  // Reset output pulse and the weak-pull latch point before its end
  localparam int RST_PULSE_CYCLES = 16;
  localparam int WKP_LATCH_LEAD_CYCLES = 4;
  localparam int RST_CNT_W = 5;
  localparam logic [RST_CNT_W-1:0] RST_CNT_LAST = 5'h0f;
  localparam logic [RST_CNT_W-1:0] WKP_LATCH_AT = 5'h0b;

  // Reset status field positions
  localparam int RSR_SRC_LSB = 0;
  localparam int RSR_BOOT_MODE = 4;
  localparam int RSR_WKP = 5;
  localparam logic [7:0] RSR_RESET_VALUE = 8'h00;

  // Pad function field
  localparam int PAD_FN_W = 4;
  localparam logic [PAD_FN_W-1:0] PAD_FN_GPIO = 4'h0;
  localparam logic [PAD_FN_W-1:0] PAD_FN_PRIMARY = 4'h1;
  localparam logic [PAD_FN_W-1:0] PAD_FN_ALT1 = 4'h2;
  localparam logic [PAD_FN_W-1:0] PAD_FN_ALT2 = 4'h4;
  localparam logic [PAD_FN_W-1:0] PAD_FN_ALT3 = 4'h8;

  // Widths
  localparam int NUM_TRIG = 4;
  localparam int NUM_IRQ = 16;
  localparam int NUM_PADS = 8;

  // Register port offsets
  localparam logic [3:0] REG_RSR = 4'h0;
  localparam logic [3:0] REG_IRQ_MUX_SEL1 = 4'h1;
  localparam logic [3:0] REG_PAD_CFG_BASE = 4'h8;
  localparam logic [15:0] IRQ_MUX_SEL1_RESET = 16'hffff;

  typedef enum logic [1:0]
  {
    SEQ_IDLE = 2'b00,
    SEQ_PULSE = 2'b01,
    SEQ_DONE = 2'b10
  } seq_state_e;

endpackage : strap_cfg_pkg

/* File: core/pin_sync.sv */
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Asynchronous pins in, synchronised out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta;

  // Two stages; only the second reads the first
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule : pin_sync

/* File: core/pad_func_sel.sv */
module pad_func_sel (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // One-hot pad function field
  input wire logic [strap_cfg_pkg::PAD_FN_W-1:0] i_fn,
  // Candidate outputs per function
  input wire logic i_gpio_out,
  input wire logic i_gpio_oe,
  input wire logic i_prim_out,
  input wire logic i_prim_oe,
  input wire logic i_mirror_out,
  // Pad and inbound paths
  input wire logic i_pad_in,
  output logic o_pad_out,
  output logic o_pad_oe,
  output logic o_prim_in,
  output logic o_alt1_in
);

  logic is_gpio;
  logic is_prim;
  logic is_alt1;
  logic is_mirror;
  logic next_out;
  logic next_oe;

  // Non one-hot codes and ALT3 fall back to GPIO
  assign is_prim = i_fn == strap_cfg_pkg::PAD_FN_PRIMARY;
  assign is_alt1 = i_fn == strap_cfg_pkg::PAD_FN_ALT1;
  assign is_mirror = i_fn == strap_cfg_pkg::PAD_FN_ALT2;
  assign is_gpio = !(is_prim || is_alt1 || is_mirror);
  assign next_out = is_prim ? i_prim_out : (is_mirror ? i_mirror_out : i_gpio_out);
  assign next_oe = is_prim ? i_prim_oe : (is_mirror ? 1'b1 : (is_gpio & i_gpio_oe));

  // Registered pad drive
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_pad_out <= 1'b0;
      o_pad_oe <= 1'b0;
      o_prim_in <= 1'b0;
      o_alt1_in <= 1'b0;
    end
    else
    begin
      o_pad_out <= next_out;
      o_pad_oe <= next_oe;
      o_prim_in <= is_prim & i_pad_in;
      // Mirror function has no inbound path
      o_alt1_in <= is_alt1 & i_pad_in;
    end
  end

endmodule : pad_func_sel

/* File: core/reset_config_strap_sampler.sv */
// The strobed register port and the address map were chosen for this implementation.
module reset_config_strap_sampler #(
  parameter bit HAS_EXT_BUS = 1'b1
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Reset request and its source
  input wire logic i_reset_req,
  input wire logic [2:0] i_reset_src,
  // Strap pins
  input wire logic [1:0] i_boot_select_straps,
  input wire logic i_weak_pull_select_strap,
  // Reset output pin
  output logic o_reset_output_pin,
  // Boot configuration
  output logic o_boot_source_bit,
  output logic o_boot_mode_bit,
  output logic [1:0] o_boot_code,
  output logic o_boot_serial,
  output logic o_boot_ext_mem,
  output logic o_boot_invalid,
  output logic o_boot_valid,
  // Timer pad weak pulls
  output logic o_weak_pullup_en,
  output logic o_weak_pulldown_en,
  // Conversion triggers
  input wire logic [strap_cfg_pkg::NUM_TRIG-1:0] i_conversion_trigger_input,
  output logic [strap_cfg_pkg::NUM_TRIG-1:0] o_queue_trigger,
  // Interrupt pins, alternate sources, mux out
  input wire logic [strap_cfg_pkg::NUM_IRQ-1:0] i_irq_pin,
  input wire logic [strap_cfg_pkg::NUM_IRQ-1:0] i_irq_alt,
  output logic [strap_cfg_pkg::NUM_IRQ-1:0] o_siu_irq,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // Demonstration pad with mirrored channel
  input wire logic i_pad_in,
  input wire logic i_gpio_out,
  input wire logic i_gpio_oe,
  input wire logic i_chan_out,
  input wire logic i_chan_oe,
  input wire logic i_mirrored_channel_output,
  output logic o_pad_out,
  output logic o_pad_oe,
  output logic o_chan_in,
  output logic o_irq_pad_in
);

  strap_cfg_pkg::seq_state_e state;
  strap_cfg_pkg::seq_state_e next_state;
  logic [strap_cfg_pkg::RST_CNT_W-1:0] cnt;
  logic [1:0] boot_sync;
  logic wkp_sync;
  logic [strap_cfg_pkg::NUM_TRIG-1:0] trig_sync;
  logic [strap_cfg_pkg::NUM_IRQ-1:0] irq_sync;
  logic [2:0] src;
  logic wkp_latched;
  logic boot_mode;
  logic boot_src;
  logic [15:0] irq_mux_sel1;
  logic [strap_cfg_pkg::PAD_FN_W-1:0] pad_fn [strap_cfg_pkg::NUM_PADS];
  logic [7:0] reset_status_reg;
  logic [15:0] next_rdata;
  logic in_pulse;
  logic at_wkp_latch;
  logic at_end;
  logic pull_live;
  logic keep_wkp;
  logic next_boot_src;
  logic [1:0] boot_code;
  logic pad_wr;
  logic pad_irq_in;

  // Decode a boot code into its boot kind
  function automatic logic is_code(input logic [1:0] code, input logic [1:0] kind);
    is_code = code == kind;
  endfunction : is_code

  // Pin synchronisers; straps, triggers and interrupt pins share one chain
  pin_sync #(
    .W(3 + strap_cfg_pkg::NUM_TRIG + strap_cfg_pkg::NUM_IRQ)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_async({i_boot_select_straps, i_weak_pull_select_strap,
      i_conversion_trigger_input, i_irq_pin}),
    .o_sync({boot_sync, wkp_sync, trig_sync, irq_sync})
  );

  // Sequence decode
  assign in_pulse = state == strap_cfg_pkg::SEQ_PULSE;
  assign at_wkp_latch = in_pulse && cnt == strap_cfg_pkg::WKP_LATCH_AT;
  assign at_end = in_pulse && cnt == strap_cfg_pkg::RST_CNT_LAST;
  // Pulls follow the live strap only while the pin stays asserted
  assign pull_live = in_pulse && !at_end;
  // Debug port and software external resets keep old weak-pull value
  assign keep_wkp = src == strap_cfg_pkg::RST_SRC_DEBUG_PORT ||
    src == strap_cfg_pkg::RST_SRC_SW_EXTERNAL;
  // No external bus: source bit forced low
  assign next_boot_src = HAS_EXT_BUS ? boot_sync[1] : 1'b0;
  assign boot_code = {boot_src, boot_mode};

  // Next state
  always_comb
  begin
    next_state = state;
    case (state)
      strap_cfg_pkg::SEQ_IDLE: next_state = strap_cfg_pkg::SEQ_PULSE;
      strap_cfg_pkg::SEQ_PULSE: next_state = at_end ? strap_cfg_pkg::SEQ_DONE : state;
      strap_cfg_pkg::SEQ_DONE: next_state = i_reset_req ? strap_cfg_pkg::SEQ_PULSE : state;
      default: next_state = strap_cfg_pkg::SEQ_IDLE;
    endcase
  end

  // Sequencer and pulse counter
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= strap_cfg_pkg::SEQ_IDLE;
      cnt <= '0;
      src <= strap_cfg_pkg::RST_SRC_POWER_ON;
    end
    else
    begin
      state <= next_state;
      cnt <= in_pulse ? cnt + 5'h01 : '0;
      if (state == strap_cfg_pkg::SEQ_DONE && i_reset_req)
      begin
        src <= i_reset_src;
      end
    end
  end

  // Reset output pin; held during the pulse
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_reset_output_pin <= 1'b1;
    end
    else
    begin
      o_reset_output_pin <= next_state == strap_cfg_pkg::SEQ_PULSE ||
        next_state == strap_cfg_pkg::SEQ_IDLE;
    end
  end

  // Strap capture, held until next pulse
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      boot_mode <= 1'b0;
      boot_src <= 1'b0;
      wkp_latched <= 1'b0;
    end
    else
    begin
      if (in_pulse)
      begin
        boot_mode <= boot_sync[0];
        boot_src <= next_boot_src;
      end
      if (at_wkp_latch && !keep_wkp)
      begin
        wkp_latched <= wkp_sync;
      end
    end
  end

  // Status word and register writes
  assign reset_status_reg = {2'h0, wkp_latched, boot_mode, 1'b0, src};
  assign pad_wr = i_wr && i_addr[3];

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      irq_mux_sel1 <= strap_cfg_pkg::IRQ_MUX_SEL1_RESET;
      for (int i = 0; i < strap_cfg_pkg::NUM_PADS; i++)
      begin
        pad_fn[i] <= strap_cfg_pkg::PAD_FN_GPIO;
      end
    end
    else
    begin
      if (i_wr && i_addr == strap_cfg_pkg::REG_IRQ_MUX_SEL1)
      begin
        irq_mux_sel1 <= i_wdata;
      end
      if (pad_wr)
      begin
        pad_fn[i_addr[2:0]] <= i_wdata[strap_cfg_pkg::PAD_FN_W-1:0];
      end
    end
  end

  // Read mux; unmapped reads zero
  always_comb
  begin
    next_rdata = 16'h0000;
    if (i_addr == strap_cfg_pkg::REG_RSR)
    begin
      next_rdata = {8'h00, reset_status_reg};
    end
    else if (i_addr == strap_cfg_pkg::REG_IRQ_MUX_SEL1)
    begin
      next_rdata = irq_mux_sel1;
    end
    else if (i_addr[3])
    begin
      next_rdata = {12'h000, pad_fn[i_addr[2:0]]};
    end
  end

  // Registered outputs
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_rdata <= 16'h0000;
      o_boot_source_bit <= 1'b0;
      o_boot_mode_bit <= 1'b0;
      o_boot_code <= strap_cfg_pkg::BOOT_INT_FLASH;
      o_boot_serial <= 1'b0;
      o_boot_ext_mem <= 1'b0;
      o_boot_invalid <= 1'b0;
      o_boot_valid <= 1'b0;
      o_weak_pullup_en <= 1'b0;
      o_weak_pulldown_en <= 1'b0;
      o_queue_trigger <= '0;
      o_siu_irq <= '0;
    end
    else
    begin
      o_rdata <= i_rd ? next_rdata : 16'h0000;
      o_boot_source_bit <= boot_src;
      o_boot_mode_bit <= boot_mode;
      o_boot_code <= boot_code;
      o_boot_serial <= is_code(boot_code, strap_cfg_pkg::BOOT_SERIAL);
      o_boot_ext_mem <= is_code(boot_code, strap_cfg_pkg::BOOT_EXT_MEM);
      o_boot_invalid <= is_code(boot_code, strap_cfg_pkg::BOOT_RESERVED);
      o_boot_valid <= state == strap_cfg_pkg::SEQ_DONE;
      // Live strap during the pulse; latched value from the pin's drop, so no late glitch
      o_weak_pullup_en <= pull_live ? wkp_sync : wkp_latched;
      o_weak_pulldown_en <= pull_live ? !wkp_sync : !wkp_latched;
      o_queue_trigger <= trig_sync;
      o_siu_irq <= (irq_mux_sel1 & irq_sync) | (~irq_mux_sel1 & i_irq_alt);
    end
  end

  assign o_irq_pad_in = pad_irq_in;

  // Pad 0: channel, irq, mirrored channel, GPIO
  pad_func_sel u_pad0 (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_fn(pad_fn[0]),
    .i_gpio_out(i_gpio_out),
    .i_gpio_oe(i_gpio_oe),
    .i_prim_out(i_chan_out),
    .i_prim_oe(i_chan_oe),
    .i_mirror_out(i_mirrored_channel_output),
    .i_pad_in(i_pad_in),
    .o_pad_out(o_pad_out),
    .o_pad_oe(o_pad_oe),
    .o_prim_in(o_chan_in),
    .o_alt1_in(pad_irq_in)
  );

endmodule : reset_config_strap_sampler

/* File: tb/strap_sampler_assertions.sv */
module strap_sampler_assertions #(
  parameter bit HAS_EXT_BUS = 1'b1
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Watched inputs
  input wire logic i_rd,
  input wire logic [strap_cfg_pkg::NUM_TRIG-1:0] i_conversion_trigger_input,
  // Watched outputs
  input wire logic o_reset_output_pin,
  input wire logic o_boot_source_bit,
  input wire logic [1:0] o_boot_code,
  input wire logic o_boot_serial,
  input wire logic o_boot_ext_mem,
  input wire logic o_boot_invalid,
  input wire logic o_weak_pullup_en,
  input wire logic o_weak_pulldown_en,
  input wire logic [strap_cfg_pkg::NUM_TRIG-1:0] o_queue_trigger,
  input wire logic [15:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);

  // Pad pulls, one of the two once reset output is low
  AST_PULL_COMPL: assert property (!o_reset_output_pin |->
    o_weak_pullup_en != o_weak_pulldown_en)
    else $error("pull enables not complementary");
  AST_PULL_HOLD: assert property (!o_reset_output_pin ##1 !o_reset_output_pin
    |-> $stable(o_weak_pullup_en)) else $error("weak pull moved outside reset");
  AST_BOOT_HOLD: assert property (!o_reset_output_pin ##1 !o_reset_output_pin
    |-> $stable(o_boot_code)) else $error("boot code moved outside reset");
  // Decodes checked only after they have settled
  AST_DECODE: assert property (!o_reset_output_pin ##1 !o_reset_output_pin
    |-> o_boot_serial == (o_boot_code == strap_cfg_pkg::BOOT_SERIAL)
    && o_boot_ext_mem == (o_boot_code == strap_cfg_pkg::BOOT_EXT_MEM)
    && o_boot_invalid == (o_boot_code == strap_cfg_pkg::BOOT_RESERVED))
    else $error("boot decode wrong");
  AST_EXT_FORCE: assert property (!HAS_EXT_BUS |-> !o_boot_source_bit && !o_boot_ext_mem)
    else $error("external boot on package without bus");
  AST_TRIG_LAT: assert property (o_queue_trigger == $past(i_conversion_trigger_input, 3))
    else $error("queue trigger not its own input");
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside read cycle");
  // Pulse long enough to hold the four-cycle latch lead
  AST_PULSE_MIN: assert property ($fell(o_reset_output_pin) |->
    $past(o_reset_output_pin, 16))
    else $error("reset output pulse too short");

  cover property ($fell(o_reset_output_pin));
  cover property (i_rd);
  cover property (o_boot_serial);
endmodule : strap_sampler_assertions

bind reset_config_strap_sampler strap_sampler_assertions #(.HAS_EXT_BUS(HAS_EXT_BUS))
  strap_sampler_assertions_i (.i_mclk, .i_arst_n, .i_rd, .i_conversion_trigger_input,
  .o_reset_output_pin, .o_boot_source_bit, .o_boot_code, .o_boot_serial, .o_boot_ext_mem,
  .o_boot_invalid, .o_weak_pullup_en, .o_weak_pulldown_en, .o_queue_trigger, .o_rdata);

/* File: tb/board_straps.sv */
module board_straps (
  // Settings from the bench
  input wire logic [1:0] i_boot_set,
  input wire logic i_wkp_set,
  input wire logic [3:0] i_trig_set,
  // Strap and trigger pins
  output logic [1:0] o_boot_select_straps,
  output logic o_weak_pull_select_strap,
  output logic [3:0] o_trig
);
  timeunit 1ns;
  timeprecision 1ns;
  // Resistors never strap the reserved code
  assign o_boot_select_straps = (i_boot_set == strap_cfg_pkg::BOOT_RESERVED) ?
    strap_cfg_pkg::BOOT_INT_FLASH : i_boot_set;
  assign o_weak_pull_select_strap = i_wkp_set;
  // One source per trigger line
  assign o_trig = i_trig_set;
endmodule : board_straps

/* File: tb/reset_config_strap_sampler_bench.sv */
module reset_config_strap_sampler_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_reset_req = 1'b0;
  logic [2:0] i_reset_src = 3'h0;
  logic [1:0] boot_set = 2'h2;
  logic wkp_set = 1'b1;
  logic [3:0] trig_set = 4'h0;
  logic [15:0] i_irq_pin = 16'h1234;
  logic [15:0] i_irq_alt = 16'hf0f0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_pad_in = 1'b1;
  logic i_gpio_out = 1'b1;
  logic i_gpio_oe = 1'b1;
  logic i_chan_out = 1'b1;
  logic i_chan_oe = 1'b1;
  logic i_mirrored_channel_output = 1'b0;
  logic [1:0] i_boot_select_straps, o_boot_code;
  logic [3:0] i_conversion_trigger_input, o_queue_trigger;
  logic [15:0] o_siu_irq, o_rdata, rd_val;
  logic i_weak_pull_select_strap, o_reset_output_pin, o_boot_source_bit, o_boot_mode_bit;
  logic o_boot_serial, o_boot_ext_mem, o_boot_invalid, o_boot_valid, o_weak_pullup_en;
  logic o_weak_pulldown_en, o_pad_out, o_pad_oe, o_chan_in, o_irq_pad_in, wk;
  logic [3:0] pad_seen;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  // Pad cases: function field, then expected {out and oe, oe, channel in, irq in}
  logic [7:0] pads [5] = '{8'h1e, 8'h21, 8'h44, 8'h0c, 8'h3c};

  board_straps board_straps_i (.i_boot_set(boot_set), .i_wkp_set(wkp_set),
    .i_trig_set(trig_set), .o_boot_select_straps(i_boot_select_straps),
    .o_weak_pull_select_strap(i_weak_pull_select_strap), .o_trig(i_conversion_trigger_input));

  reset_config_strap_sampler #(.HAS_EXT_BUS(1'b1)) reset_config_strap_sampler_i (
    .i_mclk, .i_arst_n, .i_reset_req, .i_reset_src, .i_boot_select_straps,
    .i_weak_pull_select_strap, .o_reset_output_pin, .o_boot_source_bit, .o_boot_mode_bit,
    .o_boot_code, .o_boot_serial, .o_boot_ext_mem, .o_boot_invalid, .o_boot_valid,
    .o_weak_pullup_en, .o_weak_pulldown_en, .i_conversion_trigger_input, .o_queue_trigger,
    .i_irq_pin, .i_irq_alt, .o_siu_irq, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_pad_in, .i_gpio_out, .i_gpio_oe, .i_chan_out, .i_chan_oe, .i_mirrored_channel_output,
    .o_pad_out, .o_pad_oe, .o_chan_in, .o_irq_pad_in);

  // 10 MHz clock
  initial
  begin
    forever #50 i_mclk = ~i_mclk;
  end

  // Hang guard, the run needs a few hundred cycles
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_fail++;
      test_done();
    end
  end

  task test_done;
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Sample after the edge's updates have landed
  task tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : tick

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
  endtask : rd

  task wait_pin(input logic lvl);
    for (int k = 0; k < 40 && o_reset_output_pin !== lvl; k++)
      tick(1);
    check("reset pin", {15'h0, lvl}, {15'h0, o_reset_output_pin});
  endtask : wait_pin

  // The latched pull holds on keeping sources too, so it is checked after every pulse
  task verify(input logic [2:0] src, input logic [1:0] code);
    tick(2);
    check("boot code", {14'h0, code}, {14'h0, o_boot_code});
    check("boot bits", {14'h0, code}, {14'h0, o_boot_source_bit, o_boot_mode_bit});
    check("decode", 16'({code == 2'h1, code[1]}), 16'({o_boot_serial, o_boot_ext_mem}));
    check("valid", 16'h0001, 16'({o_boot_invalid, o_boot_valid}));
    check("pulls", 16'({wk, !wk}), 16'({o_weak_pullup_en, o_weak_pulldown_en}));
    rd(strap_cfg_pkg::REG_RSR);
    check("status", {10'h0, wk, code[0], 1'b0, src}, rd_val);
  endtask : verify

  // Strap flips just before and just after the latch point
  task pulse(input logic [2:0] src, input logic [1:0] code, input logic w);
    logic upd;
    @(posedge i_mclk);
    boot_set <= code;
    wkp_set <= ~w;
    i_reset_req <= 1'b1;
    i_reset_src <= src;
    @(posedge i_mclk);
    i_reset_req <= 1'b0;
    wait_pin(1'b1);
    repeat (4) @(posedge i_mclk);
    wkp_set <= w;
    repeat (8) @(posedge i_mclk);
    wkp_set <= ~w;
    wait_pin(1'b0);
    upd = !(src inside {strap_cfg_pkg::RST_SRC_DEBUG_PORT, strap_cfg_pkg::RST_SRC_SW_EXTERNAL});
    if (upd)
      wk = w;
    verify(src, code);
  endtask : pulse

  // Main sequence
  initial
  begin
    repeat (5) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    wk = 1'b1;
    wait_pin(1'b0);
    verify(strap_cfg_pkg::RST_SRC_POWER_ON, 2'h2);
    @(posedge i_mclk);
    boot_set <= 2'h1;
    wkp_set <= 1'b0;
    tick(6);
    check("held code", 16'h0002, {14'h0, o_boot_code});
    check("held pull", 16'h0001, {15'h0, o_weak_pullup_en});
    // Sources 1 to 5 in code order; updating sources flip the pull, keeping ones try to
    for (int i = 0; i < 5; i++)
      pulse(3'(i + 1), 2'(i % 3), 1'(5'h02 >> i));
    wr(strap_cfg_pkg::REG_RSR, 16'h0007);
    rd(strap_cfg_pkg::REG_RSR);
    check("status read only", 16'h0015, rd_val);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge i_mclk);
      trig_set <= 4'h1 << i;
      tick(4);
      check("queue trigger", 16'h0001 << i, {12'h0, o_queue_trigger});
    end
    rd(strap_cfg_pkg::REG_IRQ_MUX_SEL1);
    check("mux select", 16'hffff, rd_val);
    check("irq", 16'h1234, o_siu_irq);
    wr(strap_cfg_pkg::REG_IRQ_MUX_SEL1, 16'h00ff);
    wr(4'h5, 16'hbeef);
    tick(4);
    check("irq", 16'hf034, o_siu_irq);
    rd(4'h5);
    check("unmapped", 16'h0000, rd_val);
    for (int i = 0; i < 5; i++)
    begin
      wr(strap_cfg_pkg::REG_PAD_CFG_BASE, {12'h0, pads[i][7:4]});
      tick(3);
      pad_seen = {o_pad_out & o_pad_oe, o_pad_oe, o_chan_in, o_irq_pad_in};
      check("pad", 16'(pads[i][3:0]), 16'(pad_seen));
    end
    test_done();
  end
endmodule : reset_config_strap_sampler_bench
